/* File: rtl/tcm_channel.sv */
// Timer channel: mode decode, capture/compare/PWM pin logic, value latching, AHB-Lite slave
//
// Behaviour
// - Edge/level 00 releases the channel pin.
// - Mode 00 captures rising, falling or both edges.
// - Mode 01 compares: software, toggle, clear, set.
// - Mode 1X gives edge-aligned PWM, either polarity.
// - Centre select gives centre-aligned PWM on up-match and down-match.
// - Value pair holds capture or compare value.
// - Reset clears both value bytes.
// - Capture read freezes pair until other byte.
// - Status/control write releases the read latch.
// - Compare writes buffered until both bytes written.
// - Status/control write discards partial compare pair.
// - Event flag set on edge or match.
// - Flag cleared by read-then-write-zero, event restarts.
//
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module tcm_channel
	import tcm_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [CNT_W-1:0] counter_value,
	input wire logic counter_tick,
	input wire logic counter_down,
	input wire logic counter_overflow,
	input wire logic chan_pin_in,
	output logic chan_pin_out,
	output logic chan_pin_oe,
	output logic chan_pin_released,
	output logic irq
);
	import tcm_pkg::*;

	typedef struct packed {
		logic ap_valid;
		logic ap_write;
		logic [ADDR_W-1:0] ap_addr;
		logic [31:0] rdata;
		logic flag;
		logic ie;
		logic [1:0] mode_bits;
		logic [1:0] els;
		logic cas;
		logic [CNT_W-1:0] value;
		logic [CNT_W-1:0] rd_buf;
		logic rd_latched;
		logic rd_first_hi;
		logic [CNT_W-1:0] wr_buf;
		logic wr_hi;
		logic wr_lo;
		logic clr_armed;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic pin_out;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_mask;
	} tcm_state_t;

	tcm_state_t st_ff;
	tcm_state_t nxt_st;

	// Mode decode order: edge/level 00 releases the pin whatever else is set,
	// then centre select, then mode bit 1, then mode bit 0.
	// Used for the pin driver, the capture path and the ownership outputs.

	function automatic tcm_mode_t decode_mode(input logic cas, input logic [1:0] ms,
			input logic [1:0] els);
		tcm_mode_t m;
		m = TCM_OFF;
		if (els == ELS_RELEASE) begin
			m = TCM_OFF;
		end else if (cas) begin
			m = TCM_CPWM;
		end else if (ms[1]) begin
			m = TCM_EPWM;
		end else if (ms == MS_COMPARE) begin
			m = TCM_COMPARE;
		end else begin
			m = TCM_CAPTURE;
		end
		return m;
	endfunction

	// Software compare with edge/level 00 still counts matches but owns no pin
	function automatic logic is_compare_like(input logic cas, input logic [1:0] ms);
		return cas || ms[1] || (ms == MS_COMPARE);
	endfunction

	// Bus timing:
	// - a read takes its side effects (latch, clear arm) at its address edge
	// - a write commits at the edge that ends its data phase
	// - so a read straight after a write to the same register sees the old value
	// Pin timing:
	// - two sync stages and the edge detector put a capture about three cycles
	//   after the pin moves; a slower pin costs nothing but latency
	// - pin_out follows a counter tick by one edge
	// Counter side:
	// - matches are only looked at while counter_tick is high, so a stalled
	//   counter does not fire the same match every cycle
	// Flag clear:
	// - reading status/control with the flag up arms the clear
	// - any event in between disarms it so no request is lost
	// - an event in the clearing cycle wins over the clear
	tcm_mode_t mode;
	logic ap_take;
	logic rd_take;
	logic wr_take;
	logic rise;
	logic fall;
	logic cap_event;
	logic match;
	logic event_set;
	logic [CNT_W-1:0] val_view;
	logic [31:0] rd_word;
	logic [7:0] wbyte;
	logic cmp_like;

	always_comb begin
		mode = decode_mode(st_ff.cas, st_ff.mode_bits, st_ff.els);
		cmp_like = is_compare_like(st_ff.cas, st_ff.mode_bits);
		ap_take = hsel && htrans[1] && hready;
		rd_take = ap_take && !hwrite;
		wr_take = st_ff.ap_valid && st_ff.ap_write;
		wbyte = hwdata[7:0];
		rise = st_ff.pin_s2 && !st_ff.pin_prev;
		fall = !st_ff.pin_s2 && st_ff.pin_prev;
		cap_event = 1'b0;
		if (mode == TCM_CAPTURE) begin
			case (st_ff.els)
				ELS_RISE: cap_event = rise;
				ELS_FALL: cap_event = fall;
				ELS_BOTH: cap_event = rise || fall;
				default: cap_event = 1'b0;
			endcase
		end
		match = counter_tick && cmp_like && (counter_value == st_ff.value);
		event_set = cap_event || match;
		val_view = st_ff.rd_latched ? st_ff.rd_buf : st_ff.value;
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		// Unused bits and unmapped offsets read as zero
		case (haddr[ADDR_W-1:0])
			OFS_STATUS_CONTROL: begin
				rd_word[SC_FLAG_BIT] = st_ff.flag;
				rd_word[SC_IE_BIT] = st_ff.ie;
				rd_word[SC_MODE_LSB +: 2] = st_ff.mode_bits;
				rd_word[SC_ELS_LSB +: 2] = st_ff.els;
			end
			OFS_VALUE_HIGH: rd_word[7:0] = val_view[CNT_W-1 -: 8];
			OFS_VALUE_LOW: rd_word[7:0] = val_view[7:0];
			OFS_CONFIG: rd_word[CFG_CAS_BIT] = st_ff.cas;
			OFS_IRQ_STATUS: rd_word[IRQ_W-1:0] = st_ff.irq_st;
			OFS_IRQ_MASK: rd_word[IRQ_W-1:0] = st_ff.irq_mask;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_comb begin
		nxt_st = st_ff;

		// Address phase latch; read data is prepared here so hrdata is a flop
		// hsize is ignored: every register is one aligned word
		nxt_st.ap_valid = ap_take;
		nxt_st.ap_write = hwrite;
		nxt_st.ap_addr = haddr[ADDR_W-1:0];
		if (rd_take) begin
			nxt_st.rdata = rd_word;
		end

		// Pin synchroniser; only the second stage feeds the edge detector
		nxt_st.pin_s1 = chan_pin_in;
		nxt_st.pin_s2 = st_ff.pin_s1;
		nxt_st.pin_prev = st_ff.pin_s2;


		// Capture read latch
		// Rereading the byte that froze the pair keeps it frozen;
		// only the other byte or a status/control write lets go
		if (rd_take && mode == TCM_CAPTURE) begin
			if (haddr[ADDR_W-1:0] == OFS_VALUE_HIGH || haddr[ADDR_W-1:0] == OFS_VALUE_LOW) begin
				if (!st_ff.rd_latched) begin
					nxt_st.rd_latched = 1'b1;
					nxt_st.rd_buf = st_ff.value;
					nxt_st.rd_first_hi = (haddr[ADDR_W-1:0] == OFS_VALUE_HIGH);
				end else if ((haddr[ADDR_W-1:0] == OFS_VALUE_HIGH) != st_ff.rd_first_hi) begin
					nxt_st.rd_latched = 1'b0;
				end
			end
		end


		// Reading status/control with the flag up arms the clear
		if (rd_take && haddr[ADDR_W-1:0] == OFS_STATUS_CONTROL && st_ff.flag) begin
			nxt_st.clr_armed = 1'b1;
		end

		if (cap_event) begin
			nxt_st.value = counter_value;
		end

		if (wr_take) begin
			case (st_ff.ap_addr)
				OFS_STATUS_CONTROL: begin
					nxt_st.ie = wbyte[SC_IE_BIT];
					nxt_st.mode_bits = wbyte[SC_MODE_LSB +: 2];
					nxt_st.els = wbyte[SC_ELS_LSB +: 2];
					nxt_st.rd_latched = 1'b0;
					nxt_st.wr_hi = 1'b0;
					nxt_st.wr_lo = 1'b0;
					if (st_ff.clr_armed && !wbyte[SC_FLAG_BIT]) begin
						nxt_st.flag = 1'b0;
					end
					nxt_st.clr_armed = 1'b0;
				end
				OFS_VALUE_HIGH, OFS_VALUE_LOW: begin
					// Compare/PWM buffers the byte, capture writes it straight through
					if (cmp_like) begin
						if (st_ff.ap_addr == OFS_VALUE_HIGH) begin
							nxt_st.wr_buf[CNT_W-1 -: 8] = wbyte;
							nxt_st.wr_hi = 1'b1;
						end else begin
							nxt_st.wr_buf[7:0] = wbyte;
							nxt_st.wr_lo = 1'b1;
						end
					end else if (st_ff.ap_addr == OFS_VALUE_HIGH) begin
						nxt_st.value[CNT_W-1 -: 8] = wbyte;
					end else begin
						nxt_st.value[7:0] = wbyte;
					end
				end
				OFS_CONFIG: nxt_st.cas = wbyte[CFG_CAS_BIT];
				OFS_IRQ_STATUS: nxt_st.irq_st = st_ff.irq_st & ~hwdata[IRQ_W-1:0];
				OFS_IRQ_MASK: nxt_st.irq_mask = hwdata[IRQ_W-1:0];
				default: nxt_st.irq_mask = nxt_st.irq_mask;
			endcase
		end

		// Buffered bytes survive until both halves arrive or status/control is written
		// Both bytes present: move the pair as one word
		if (nxt_st.wr_hi && nxt_st.wr_lo) begin
			nxt_st.value = nxt_st.wr_buf;
			nxt_st.wr_hi = 1'b0;
			nxt_st.wr_lo = 1'b0;
		end

		// Set wins over any clear in the same cycle; a new event restarts the sequence
		if (event_set) begin
			nxt_st.flag = 1'b1;
			nxt_st.clr_armed = 1'b0;
			nxt_st.irq_st[IRQ_EVENT_BIT] = 1'b1;
		end
		if (cap_event) begin
			nxt_st.irq_st[IRQ_CAPTURE_BIT] = 1'b1;
		end


		// Pin driver
		// Mode changes leave pin_out alone so that a PWM output does not glitch
		// when software moves between polarities; the next event sets it right
		case (mode)
			TCM_COMPARE: begin
				if (match) begin
					case (st_ff.els)
						ELS_TOGGLE: nxt_st.pin_out = !st_ff.pin_out;
						ELS_CLEAR: nxt_st.pin_out = 1'b0;
						ELS_SET: nxt_st.pin_out = 1'b1;
						default: nxt_st.pin_out = st_ff.pin_out;
					endcase
				end
			end
			TCM_EPWM: begin
				// Overflow starts the period, the match ends the pulse
				if (match) begin
					nxt_st.pin_out = st_ff.els[0];
				end else if (counter_overflow) begin
					nxt_st.pin_out = !st_ff.els[0];
				end
			end
			TCM_CPWM: begin
				if (match && !counter_down) begin
					nxt_st.pin_out = st_ff.els[0];
				end else if (match && counter_down) begin
					nxt_st.pin_out = !st_ff.els[0];
				end
			end
			default: nxt_st.pin_out = st_ff.pin_out;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Everything clears; the named fields restate their own resets
			st_ff <= '0;
			st_ff.value <= RST_VALUE;
			st_ff.rd_buf <= RST_VALUE;
			st_ff.wr_buf <= RST_VALUE;
			st_ff.mode_bits <= RST_MODE_BITS;
			st_ff.els <= RST_ELS;
			st_ff.irq_mask <= RST_IRQ_MASK;
		end else begin
			st_ff <= nxt_st;
		end
	end


	// Zero-wait slave: every transfer completes with OKAY.
	// A slower register file would drive hreadyout from a wait counter here.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_ff.rdata;

	// Pin outputs: the drive value is registered, ownership decodes the mode
	assign chan_pin_out = st_ff.pin_out;
	// Software-only compare keeps the pin released as well
	assign chan_pin_released = (mode == TCM_OFF) || (mode == TCM_CAPTURE);
	assign chan_pin_oe = (mode == TCM_COMPARE) || (mode == TCM_EPWM) || (mode == TCM_CPWM);

	// Interrupt: channel enable path or the summary mask path
	assign irq = (st_ff.flag && st_ff.ie) || |(st_ff.irq_st & st_ff.irq_mask);


	// Address bits above the decoded range and upper write bytes are ignored
	logic unused_ok;
	assign unused_ok = ^{haddr[31:ADDR_W], hsize, hwdata[31:8]};
endmodule

/* File: rtl/tcm_pkg.sv */
// Package: register map, field layout, reset values and modes of the timer channel
package tcm_pkg;
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_VALUE_HIGH = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_VALUE_LOW = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CONFIG = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

	// Fields of channel_status_control
	localparam int SC_FLAG_BIT = 7;
	localparam int SC_IE_BIT = 6;
	localparam int SC_MODE_LSB = 4;
	localparam int SC_ELS_LSB = 2;
	// Field of config
	localparam int CFG_CAS_BIT = 0;
	// Fields of irq status and mask
	localparam int IRQ_EVENT_BIT = 0;
	localparam int IRQ_CAPTURE_BIT = 1;
	localparam int IRQ_W = 2;

	localparam logic [1:0] ELS_RELEASE = 2'h0;
	localparam logic [1:0] ELS_RISE = 2'h1;
	localparam logic [1:0] ELS_FALL = 2'h2;
	localparam logic [1:0] ELS_BOTH = 2'h3;
	localparam logic [1:0] ELS_CLEAR = 2'h2;
	localparam logic [1:0] ELS_SET = 2'h3;
	localparam logic [1:0] ELS_TOGGLE = 2'h1;
	localparam logic [1:0] MS_CAPTURE = 2'h0;
	localparam logic [1:0] MS_COMPARE = 2'h1;

	localparam logic [15:0] RST_VALUE = 16'h0000;
	localparam logic [1:0] RST_MODE_BITS = 2'h0;
	localparam logic [1:0] RST_ELS = 2'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

	typedef enum logic [2:0] {
		TCM_OFF,
		TCM_CAPTURE,
		TCM_COMPARE,
		TCM_EPWM,
		TCM_CPWM
	} tcm_mode_t;
endpackage

/* File: test/tcm_pin_model.sv */
// Pin partner: outside driver owning the channel pin whenever the channel lets go
`timescale 1ns/1ps
module tcm_pin_model (
	input logic ext_level,
	input logic pin_out,
	input logic pin_oe,
	output logic pin_level
);
	// Outside level moves only on bench command, held several cycles between moves
	assign pin_level = pin_oe ? pin_out : ext_level;
endmodule

/* File: test/tcm_properties.sv */
// Checker: bus answer, pin ownership and what may move the outputs
`timescale 1ns/1ps
module tcm_properties (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic [31:0] hrdata,
	input logic counter_tick,
	input logic counter_overflow,
	input logic chan_pin_out,
	input logic chan_pin_oe,
	input logic chan_pin_released,
	input logic irq
);
	wire take = hsel && htrans[1] && hready;
	wire cnt_ev = counter_tick || counter_overflow;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_unmapped_read;
		take && !hwrite && haddr[7:0] == 8'h18;
	endsequence
	sequence s_write_taken;
		take && hwrite ##2 1'b1;
	endsequence
	a_ready_high: assert property (hreadyout == 1'b1)
		else $error("hreadyout low");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	a_pin_owner: assert property (chan_pin_oe != chan_pin_released)
		else $error("pin owner flags disagree");
	a_pin_cause: assert property ($changed(chan_pin_out) |->
		$past(cnt_ev) || $past(cnt_ev, 2)) else $error("pin moved without counter event");
	a_owner_cause: assert property ($changed(chan_pin_oe) |->
		$past(take && hwrite, 2)) else $error("pin owner moved without write");
	a_rdata_hold: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
		else $error("read data moved without read");
	a_irq_fall: assert property ($fell(irq) |-> $past(take && hwrite, 2))
		else $error("irq dropped without write");
	a_unmapped_zero: assert property (s_unmapped_read |=> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	c_write: cover property (s_write_taken);
endmodule
bind tcm_channel tcm_properties chk_u (.*);

/* File: test/test_timer_channel_mode_value.sv */
// Bench: bus, counter and pin stimulus against a reference of pin, value and flag
`timescale 1ns/1ps
module test_timer_channel_mode_value;
	import tcm_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq, pin;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [15:0] counter_value = 0;
	logic counter_tick = 0, counter_down = 0, counter_overflow = 0, ext_level = 0;
	logic chan_pin_out, chan_pin_oe, chan_pin_released;
	int num_errors = 0, total_checks = 0, ms, el, ca, val = 0, mpin = 0, v, e;
	assign hready = hreadyout;
	always #25 hclk = ~hclk;
	tcm_channel dut_u (.*, .chan_pin_in(pin));
	tcm_pin_model pm_u (.ext_level(ext_level), .pin_out(chan_pin_out),
		.pin_oe(chan_pin_oe), .pin_level(pin));
	task results;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		q = hrdata;
		#1;
	endtask
	task cfg(input int c, input int m, input int x, input int ie);
		ca = c;
		ms = m;
		el = x;
		bus(1, OFS_CONFIG, c);
		bus(1, OFS_STATUS_CONTROL, (ie << SC_IE_BIT) | (m << SC_MODE_LSB) | (x << SC_ELS_LSB));
		chk(chan_pin_released, x == 0 || (m == 0 && c == 0));
		chk(chan_pin_oe, !(x == 0 || (m == 0 && c == 0)));
	endtask
	task tick(input logic [15:0] c, input logic dn, input logic ov);
		counter_value <= c;
		counter_down <= dn;
		counter_overflow <= ov;
		counter_tick <= 1'b1;
		@(posedge hclk);
		counter_tick <= 1'b0;
		counter_overflow <= 1'b0;
		@(posedge hclk);
		#1;
		if (c == val) begin
			if (ca)
				mpin = dn ? !el[0] : el[0];
			else if (ms >= 2)
				mpin = el[0];
			else if (ms == 1 && el != 0)
				mpin = el == 1 ? !mpin : el - 2;
		end else if (ov && !ca && ms >= 2)
			mpin = !el[0];
		chk(chan_pin_out, mpin);
	endtask
	task edge_in(input logic [15:0] c);
		counter_value <= c;
		ext_level <= 1'b0;
		repeat (4) @(posedge hclk);
		ext_level <= 1'b1;
		repeat (6) @(posedge hclk);
		#1;
	endtask
	initial begin
		#200000;
		num_errors++;
		results();
	end
	initial begin
		void'($urandom(48916));
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		bus(0, OFS_VALUE_HIGH, 0);
		chk(q, RST_VALUE[15:8]);
		bus(0, OFS_VALUE_LOW, 0);
		chk(q, RST_VALUE[7:0]);
		bus(0, 8'h18, 0);
		chk(q, 0);
		cfg(0, MS_CAPTURE, ELS_RISE, 1);
		v = $urandom_range(16'hffff);
		edge_in(v);
		chk(irq, 1);
		bus(0, OFS_VALUE_HIGH, 0);
		chk(q, v[15:8]);
		edge_in(v + 1);
		bus(0, OFS_VALUE_LOW, 0);
		chk(q, v[7:0]);
		bus(0, OFS_VALUE_LOW, 0);
		chk(q, 8'(v + 1));
		edge_in(v + 2);
		bus(0, OFS_STATUS_CONTROL, 0);
		chk(q[SC_FLAG_BIT], 1);
		bus(1, OFS_STATUS_CONTROL, (1 << SC_IE_BIT) | (ELS_RISE << SC_ELS_LSB));
		chk(irq, 0);
		bus(0, OFS_VALUE_LOW, 0);
		chk(q, 8'(v + 2));
		cfg(0, MS_COMPARE, ELS_SET, 1);
		v = $urandom_range(16'hffff, 1);
		bus(1, OFS_VALUE_HIGH, v[15:8]);
		bus(1, OFS_VALUE_LOW, v[7:0]);
		val = v;
		bus(1, OFS_VALUE_HIGH, 0);
		cfg(0, MS_COMPARE, ELS_SET, 1);
		bus(1, OFS_VALUE_LOW, 0);
		tick(v, 0, 0);
		chk(irq, 1);
		bus(1, OFS_VALUE_HIGH, 0);
		val = 0;
		for (e = 1; e < 4; e++) begin
			cfg(0, MS_COMPARE, e, 0);
			tick(0, 0, 0);
		end
		for (e = 2; e < 4; e++) begin
			cfg(0, 2, e, 0);
			tick(16'h0005, 0, 1);
			tick(0, 0, 0);
			cfg(1, 0, e, 0);
			tick(0, 0, 0);
			tick(0, 1, 0);
		end
		for (e = 2; e < 4; e++) begin
			cfg(0, MS_CAPTURE, e, 0);
			v = $urandom_range(16'hffff);
			edge_in(v);
			bus(0, OFS_VALUE_LOW, 0);
			chk(q, v[7:0]);
		end
		bus(1, OFS_IRQ_MASK, 1);
		bus(0, OFS_IRQ_MASK, 0);
		chk(q, 1);
		chk(irq, 1);
		bus(1, OFS_IRQ_STATUS, 1);
		chk(irq, 0);
		results();
	end
endmodule
